//--- core/spd_device.sv
// device end: pin power-down hold around a small registered logic core
//
// Notes on behaviour
// [R1] sleep exists only when option enabled
// [R2] request pin dedicated to sleep, not signal
// [R3] asleep while request high, awake when low
// [R4] either of two request pins sleeps
// [R5] outputs and internal state frozen while asleep
// [R6] released outputs stay released while asleep
// [R7] all other inputs ignored while asleep
// [R8] pin keepers hold last levels while asleep
// [R9] request pin never feeds the logic
// [R10] request pin macrocell stays usable internally
// [R11] system holds inputs steady before request
// [R12] system holds inputs steady after request
// [R13] inputs accepted again within one microsecond
// [R14] enables and clocks effective within one microsecond
// [R15] outputs re-evaluated within one microsecond of exit
// [R16] wake resumes from held state, no reinit
// [R17] system drives one clean edge per change
`timescale 1ns/100ps
`default_nettype none
module spd_device #(
  parameter bit          SLEEP_ENABLE = 1'b1,   // design-time sleep option
  parameter int unsigned W            = spd_pkg::DATA_W,
  parameter int unsigned RECOVER      = spd_pkg::RECOVER_CYC
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  spd_if.dev                link,
  input  wire logic [W-1:0] oe_ctrl_i,     // user: drive enable, high drives
  input  wire logic         core_en_i,     // user: logic core accumulate
  output logic      [W-1:0] core_state_o,  // user: internal register view
  output logic              asleep_o       // user: hold state indicator
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  initial begin
    if (W < 1 || W > 64) $error("spd_device: W out of range");
    if (RECOVER < 1 || RECOVER > 65535) $error("spd_device: bad RECOVER");
  end

  typedef enum logic [1:0] {
    SPD_AWAKE   = 2'b00,  // normal evaluation
    SPD_ASLEEP  = 2'b01,  // everything frozen
    SPD_RECOVER = 2'b10   // waking, outputs still held
  } spd_state_t;

  ////////////////////////////////////////////////////////////////////////
  // request decode
  logic             sleep_req;      // combined request level
  spd_state_t       state_r;        // sleep state
  spd_state_t       state_nxt;      // its next value
  logic [15:0]      rec_cnt_r;      // recovery countdown
  logic [W-1:0]     core_r;         // internal logic state
  logic [W-1:0]     keep_in_r;      // input keeper latches
  logic [W-1:0]     pad_out_r;      // pin output values
  logic [W-1:0]     pad_oe_n_r;     // pin enables, low drives
  logic             run;            // core may evaluate

  // the request pins only reach this decode, never the core
  always_comb begin
    sleep_req = SLEEP_ENABLE &&                                   // R1
      (link.sleep_request_first || link.sleep_request_second);    // R2 R4 R9
  end

  ////////////////////////////////////////////////////////////////////////
  // state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SPD_AWAKE:   if (sleep_req) state_nxt = SPD_ASLEEP;         // R3
      SPD_ASLEEP:  if (!sleep_req) state_nxt = SPD_RECOVER;       // R3
      // a new request during recovery sleeps again at once
      SPD_RECOVER: begin
        if (sleep_req) state_nxt = SPD_ASLEEP;
        else if (rec_cnt_r == 16'h0001) state_nxt = SPD_AWAKE;    // R15
      end
      default:     state_nxt = SPD_AWAKE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r <= SPD_AWAKE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // recovery counter, worst case used so system timing stays safe
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rec_cnt_r <= 16'h0000;
    end else if (state_nxt == SPD_RECOVER && state_r != SPD_RECOVER) begin
      rec_cnt_r <= 16'(RECOVER);                                  // R13 R14
    end else if (state_r == SPD_RECOVER && rec_cnt_r != 16'h0000) begin
      rec_cnt_r <= rec_cnt_r - 16'h0001;
    end
  end

  // core runs only when awake and not about to sleep
  assign run = (state_r == SPD_AWAKE) && !sleep_req;              // R7

  ////////////////////////////////////////////////////////////////////////
  // input keepers: capture pins only while running
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      keep_in_r <= W'(spd_pkg::DATA_RST);
    end else if (run) begin
      keep_in_r <= link.data_in;
    end                                                           // R8 R7
  end

  // internal logic: keeps counting through the request pin's cell
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      core_r <= W'(spd_pkg::DATA_RST);
    end else if (run && core_en_i) begin
      core_r <= core_r + keep_in_r;     // R10 R16
    end                                 // R5
  end

  // pin outputs and enables frozen, released pins stay released
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pad_out_r  <= W'(spd_pkg::DATA_RST);
      pad_oe_n_r <= '1;
    end else if (run) begin
      pad_out_r  <= core_r;
      pad_oe_n_r <= ~oe_ctrl_i;         // R14
    end                                 // R5 R6
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      asleep_o     <= 1'b0;
      core_state_o <= W'(spd_pkg::DATA_RST);
      link.outputs_valid <= 1'b1;
    end else begin
      asleep_o     <= (state_nxt == SPD_ASLEEP);
      core_state_o <= core_r;
      link.outputs_valid <= (state_nxt == SPD_AWAKE);             // R15
    end
  end

  assign link.pad_out  = pad_out_r;
  assign link.pad_oe_n = pad_oe_n_r;

endmodule : spd_device
`default_nettype wire

//--- core/spd_if.sv
// interface joining the sleeping device end and the system logic end
`timescale 1ns/100ps
`default_nettype none
interface spd_if #(
  parameter int unsigned W = 8
);
  logic         sleep_request_first;   // first request pin, high = sleep
  logic         sleep_request_second;  // second request pin, high = sleep
  logic [W-1:0] data_in;               // system to device inputs
  logic [W-1:0] pad_out;               // device pin output values
  logic [W-1:0] pad_oe_n;              // device pin enables, low drives
  logic         outputs_valid;         // device recovered and evaluating

  modport dev (
    input  sleep_request_first, sleep_request_second, data_in,
    output pad_out, pad_oe_n, outputs_valid
  );
  modport sys (
    output sleep_request_first, sleep_request_second, data_in,
    input  pad_out, pad_oe_n, outputs_valid
  );
endinterface : spd_if
`default_nettype wire

//--- core/spd_pkg.sv
// package of constants shared by both ends of the sleep hold link
package spd_pkg;
  localparam int unsigned CLK_PERIOD_PS     = 10000;  // 100 MHz clock period
  localparam int unsigned SETUP_NS          = 15;     // inputs valid before request
  localparam int unsigned SETUP_SLOW_NS     = 20;     // same, slower grade
  localparam int unsigned DONTCARE_NS       = 25;     // inputs held after request
  localparam int unsigned DONTCARE_SLOW_NS  = 30;     // same, slower grade
  localparam int unsigned RECOVER_US        = 1;      // exit to valid operation
  // least times round up, longest times round down
  localparam int unsigned SETUP_CYC      =
    (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETUP_SLOW_CYC =
    (SETUP_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HOLD_CYC       =
    (DONTCARE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HOLD_SLOW_CYC  =
    (DONTCARE_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RECOVER_CYC    =
    (RECOVER_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned DATA_W         = 8;       // default pin group width
  localparam logic [7:0]  DATA_RST       = 8'h00;   // register reset value
endpackage : spd_pkg

//--- core/spd_system.sv
// system end: drives sleep request and inputs with documented margins
`timescale 1ns/100ps
`default_nettype none
module spd_system #(
  parameter int unsigned W       = spd_pkg::DATA_W,
  parameter bit          SLOW    = 1'b0,   // slower grade timing
  parameter int unsigned RECOVER = spd_pkg::RECOVER_CYC
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  spd_if.sys                link,
  input  wire logic         sleep_i,      // user: want sleep (level)
  input  wire logic         use_second_i, // user: use second request pin
  input  wire logic [W-1:0] data_i,       // user: data for device inputs
  output logic              busy_o,       // user: sequencing in progress
  output logic              ready_o       // user: device usable
);

  initial begin
    if (W < 1 || RECOVER < 1 || RECOVER > 65535)
      $error("spd_system: bad parameters");
  end

  localparam int unsigned SETUP = SLOW ? spd_pkg::SETUP_SLOW_CYC
                                       : spd_pkg::SETUP_CYC;
  localparam int unsigned HOLD  = SLOW ? spd_pkg::HOLD_SLOW_CYC
                                       : spd_pkg::HOLD_CYC;

  typedef enum logic [2:0] {
    SPS_RUN    = 3'b000,  // data follows user
    SPS_SETUP  = 3'b001,  // data frozen before request
    SPS_HOLD   = 3'b010,  // request high, data still frozen
    SPS_SLEEP  = 3'b011,  // request high, data free
    SPS_WAKE   = 3'b100   // request low, waiting recovery
  } sps_state_t;

  sps_state_t  state_r;    // sequencer state
  sps_state_t  state_nxt;  // its next value
  logic [15:0] cnt_r;      // phase counter
  logic [15:0] lim;        // length of current phase

  ////////////////////////////////////////////////////////////////////////
  // phase lengths
  always_comb begin
    case (state_r)
      SPS_SETUP: lim = 16'(SETUP);                                // R11
      SPS_HOLD:  lim = 16'(HOLD);                                 // R12
      SPS_WAKE:  lim = 16'(RECOVER);                              // R13
      default:   lim = 16'h0001;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SPS_RUN:   if (sleep_i) state_nxt = SPS_SETUP;
      SPS_SETUP: if (cnt_r + 16'h0001 >= lim) state_nxt = SPS_HOLD;
      SPS_HOLD:  if (cnt_r + 16'h0001 >= lim) state_nxt = SPS_SLEEP;
      SPS_SLEEP: if (!sleep_i) state_nxt = SPS_WAKE;
      SPS_WAKE:  if (cnt_r + 16'h0001 >= lim) state_nxt = SPS_RUN; // R14
      default:   state_nxt = SPS_RUN;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r <= SPS_RUN;
      cnt_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt == state_r) ? cnt_r + 16'h0001 : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pins: one clean edge per entry and exit
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      link.sleep_request_first  <= 1'b0;
      link.sleep_request_second <= 1'b0;
      link.data_in              <= '0;
      busy_o                    <= 1'b0;
      ready_o                   <= 1'b1;
    end else begin
      link.sleep_request_first  <= !use_second_i &&              // R17
        (state_nxt == SPS_HOLD || state_nxt == SPS_SLEEP);
      link.sleep_request_second <= use_second_i &&
        (state_nxt == SPS_HOLD || state_nxt == SPS_SLEEP);
      if (state_nxt == SPS_RUN || state_nxt == SPS_SLEEP)
        link.data_in <= data_i;                                   // R11 R12
      busy_o  <= (state_nxt != SPS_RUN);
      ready_o <= (state_nxt == SPS_RUN);
    end
  end

endmodule : spd_system
`default_nettype wire

//--- sim/spd_asserts.sv
// concurrent checks on the signals of the sleep hold link
`timescale 1ns/100ps
`default_nettype none
module spd_asserts #(
  parameter int unsigned W       = 8,
  parameter int unsigned RECOVER = 4
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic         sleep_request_first,
  input  wire logic         sleep_request_second,
  input  wire logic [W-1:0] data_in,
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] pad_oe_n,
  input  wire logic         outputs_valid
);
  localparam int WAKE_MAX = RECOVER + 1;  // latest wake edge after exit
  // either pin asks for sleep
  wire logic req_any = sleep_request_first | sleep_request_second;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  //////////////////////////////////////////////////////////////////////////
  a_pads_frozen: assert property (req_any |=> $stable(pad_out))
    else $error("pad values moved while asleep");
  a_enables_frozen: assert property (req_any |=> $stable(pad_oe_n))
    else $error("pad enables moved while asleep");
  a_valid_dropped: assert property (req_any |=> !outputs_valid)
    else $error("outputs valid while asleep");
  a_recovery_held: assert property ($fell(req_any) |->
    (!outputs_valid && $stable(pad_out)) [*3])
    else $error("device woke before recovery");
  a_wake_bound: assert property ($fell(req_any) |->
    ##[1:WAKE_MAX] outputs_valid)
    else $error("device did not wake in time");
  a_setup_kept: assert property ($rose(req_any) |-> $stable(data_in))
    else $error("inputs changed too close before request");
  a_hold_kept: assert property ($rose(req_any) |=> $stable(data_in) [*2])
    else $error("inputs changed too soon after request");
  // a clean request level: no short glitch on entry
  a_clean_level: assert property ($rose(req_any) |-> req_any [*3])
    else $error("request pulse too short");
endmodule : spd_asserts
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench: system end and device end joined by the link
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned W   = 8;
  localparam int unsigned REC = 4;  // shortened recovery keeps runs short
  logic         clock_i, reset_i, sleep_i, use_second_i, core_en_i;
  logic [W-1:0] data_i, oe_ctrl_i, core_state_o;
  logic [W-1:0] held_core, held_pad, held_oe;  // values seen at freeze
  logic         asleep_o, busy_o, ready_o, off_asleep, off_slept;
  int           num_errors, n_tests, cnt;
  spd_if #(.W(W)) lk ();      // main link
  spd_if #(.W(W)) lk_off ();  // link to a device built without sleep
  //////////////////////////////////////////////////////////////////////////
  spd_system #(.W(W), .SLOW(1'b0), .RECOVER(REC)) i_spd_system (
    .clock_i(clock_i), .reset_i(reset_i), .link(lk.sys),
    .sleep_i(sleep_i), .use_second_i(use_second_i), .data_i(data_i),
    .busy_o(busy_o), .ready_o(ready_o));
  spd_device #(.SLEEP_ENABLE(1'b1), .W(W), .RECOVER(REC)) i_spd_device (
    .clock_i(clock_i), .reset_i(reset_i), .link(lk.dev),
    .oe_ctrl_i(oe_ctrl_i), .core_en_i(core_en_i),
    .core_state_o(core_state_o), .asleep_o(asleep_o));
  spd_system #(.W(W), .SLOW(1'b0), .RECOVER(REC)) i_spd_system_off (
    .clock_i(clock_i), .reset_i(reset_i), .link(lk_off.sys),
    .sleep_i(sleep_i), .use_second_i(use_second_i), .data_i(data_i),
    .busy_o(), .ready_o());
  spd_device #(.SLEEP_ENABLE(1'b0), .W(W), .RECOVER(REC)) i_spd_device_off (
    .clock_i(clock_i), .reset_i(reset_i), .link(lk_off.dev),
    .oe_ctrl_i(oe_ctrl_i), .core_en_i(core_en_i),
    .core_state_o(), .asleep_o(off_asleep));
  spd_asserts #(.W(W), .RECOVER(REC)) i_spd_asserts (
    .clock_i(clock_i), .reset_i(reset_i),
    .sleep_request_first(lk.sleep_request_first),
    .sleep_request_second(lk.sleep_request_second),
    .data_in(lk.data_in), .pad_out(lk.pad_out),
    .pad_oe_n(lk.pad_oe_n), .outputs_valid(lk.outputs_valid));
  //////////////////////////////////////////////////////////////////////////
  // clock, and a sticky flag for the option-less device
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (off_asleep === 1'b1) off_slept <= 1'b1;
  end
  // expected enables: high control drives, so enable goes low
  function automatic logic [W-1:0] exp_oe(input logic [W-1:0] oe);
    return ~oe;
  endfunction : exp_oe
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////////
  // watchdog: far beyond sixteen sleep cycles of some twenty-five edges
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    complete_run;
  end
  initial begin
    reset_i = 1'b1; sleep_i = 1'b0; use_second_i = 1'b0; core_en_i = 1'b0;
    data_i = 8'h00; oe_ctrl_i = 8'h00; off_slept = 1'b0;
    num_errors = 0; n_tests = 0;
    void'($urandom(32'hb9c9));
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      // awake traffic; first two rounds pin the enables at the extremes
      repeat (4) begin
        @(posedge clock_i);
        data_i    <= W'($urandom);
        core_en_i <= 1'($urandom);
        oe_ctrl_i <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : W'($urandom);
      end
      @(posedge clock_i);
      sleep_i      <= 1'b1;
      use_second_i <= i[0];  // alternate the two request pins
      cnt = 0;
      while (asleep_o !== 1'b1 && cnt < 50) begin
        @(posedge clock_i);
        cnt++;
      end
      check(asleep_o, 1'b1);
      held_core = core_state_o;
      held_pad  = lk.pad_out;
      held_oe   = lk.pad_oe_n;
      // inputs churn while asleep and must change nothing
      repeat (6) begin
        @(posedge clock_i);
        data_i    <= W'($urandom);
        oe_ctrl_i <= W'($urandom);
        core_en_i <= 1'b1;
      end
      @(posedge clock_i);
      check(core_state_o, held_core);
      check(lk.pad_out, held_pad);
      check(lk.pad_oe_n, held_oe);
      check(busy_o, 1'b1);
      sleep_i   <= 1'b0;
      core_en_i <= 1'b0;
      cnt = 0;
      while (ready_o !== 1'b1 && cnt < 50) begin
        @(posedge clock_i);
        cnt++;
      end
      check(ready_o, 1'b1);
      repeat (2) @(posedge clock_i);
      check(core_state_o, held_core);
      check(asleep_o, 1'b0);
      check(busy_o, 1'b0);
      check(lk.outputs_valid, 1'b1);
      check(lk.pad_oe_n, exp_oe(oe_ctrl_i));
    end
    check(off_slept, 1'b0);
    complete_run;
  end
endmodule : testbench
`default_nettype wire
